// ### rpae_defines.vh
// Constants for the root port advanced error logging block
`ifndef RPAE_DEFINES_VH
`define RPAE_DEFINES_VH

// ============================================================
// Configuration space offsets
`define RPAE_OFS_UNC_STATUS   12'h144
`define RPAE_OFS_UNC_MASK     12'h148
`define RPAE_OFS_UNC_SEVER    12'h14C
`define RPAE_OFS_CAP_CTRL     12'h158
`define RPAE_OFS_HDR_DW0      12'h15C
`define RPAE_OFS_HDR_DW1      12'h160
`define RPAE_OFS_HDR_DW2      12'h164
`define RPAE_OFS_HDR_DW3      12'h168
`define RPAE_OFS_ROOT_CMD     12'h16C
`define RPAE_OFS_ROOT_FLAGS   12'h170
`define RPAE_OFS_SRC_REQ      12'h174

// ============================================================
// Uncorrectable error register layout
`define RPAE_UNC_IMPL         32'h001F_F030
`define RPAE_UNC_SEVER_RST    32'h0006_2030
`define RPAE_UNC_MASK_RST     32'h0000_0000

// ============================================================
// Capability and control fields
`define RPAE_CC_PTR_HI        4
`define RPAE_CC_PTR_LO        0
`define RPAE_CC_GEN_ABLE      5
`define RPAE_CC_GEN_ON        6
`define RPAE_CC_VER_ABLE      7
`define RPAE_CC_VER_ON        8

// ============================================================
// Root command and root flag fields
`define RPAE_CMD_COR          0
`define RPAE_CMD_NF           1
`define RPAE_CMD_FAT          2
`define RPAE_CMD_WIDTH        3
`define RPAE_FL_COR_SEEN      0
`define RPAE_FL_COR_REP       1
`define RPAE_FL_UNC_SEEN      2
`define RPAE_FL_UNC_REP       3
`define RPAE_FL_FIRST_FAT     4
`define RPAE_FL_NF_ARR        5
`define RPAE_FL_FAT_ARR       6
`define RPAE_FL_WIDTH         7
`define RPAE_VEC_HI           31
`define RPAE_VEC_LO           27

// ============================================================
// Error message codes carried in the message header
`define RPAE_MSG_ERR_COR      8'h30
`define RPAE_MSG_ERR_NF       8'h31
`define RPAE_MSG_ERR_FAT      8'h33

`endif

// ### rpae_msg_decode.v
// Decoder that classifies received error messages
`timescale 1ns/1ps
`default_nettype none
`include "rpae_defines.vh"

module rpae_msg_decode
(
    // Received message
    input  wire        msg_valid,
    input  wire [7:0]  msg_code,
    // Classified pulses
    output wire        is_cor,
    output wire        is_nf,
    output wire        is_fat
);

    // ============================================================
    // Code match; unknown codes are dropped here on purpose
    assign is_cor = msg_valid & (msg_code == `RPAE_MSG_ERR_COR);
    assign is_nf  = msg_valid & (msg_code == `RPAE_MSG_ERR_NF);
    assign is_fat = msg_valid & (msg_code == `RPAE_MSG_ERR_FAT);

endmodule // rpae_msg_decode
`default_nettype wire

// ### rpae_error_log.v
// Root port advanced error logging, flags and configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "rpae_defines.vh"

module rpae_error_log
#(
    parameter       GEN_ABLE   = 1'b0,
    parameter       VER_ABLE   = 1'b0,
    parameter [4:0] IRQ_VECTOR = 5'h0
)
(
    // Clock and reset
    input  wire         clock,
    input  wire         srst,
    // Configuration access
    input  wire         cfg_wr,
    input  wire         cfg_rd,
    input  wire [11:0]  cfg_addr,
    input  wire [3:0]   cfg_be,
    input  wire [31:0]  cfg_wdata,
    output wire [31:0]  cfg_rdata,
    output wire         cfg_rvalid,
    // Errors detected by this port
    input  wire         det_valid,
    input  wire [4:0]   det_bit,
    input  wire [127:0] det_header,
    // Error messages sent upstream by this port
    output wire         err_msg_valid,
    output wire         err_msg_fatal,
    // Error messages received from below
    input  wire         msg_valid,
    input  wire [7:0]   msg_code,
    input  wire [15:0]  msg_req_id,
    // Data path controls
    output wire         end_crc_generate_on,
    output wire         end_crc_verify_on,
    // Interrupt request and vector
    output wire         aer_irq_req,
    output wire [4:0]   aer_irq_vector_number
);

    // ============================================================
    // Storage
    reg  [31:0]  unc_status_reg;
    reg  [31:0]  unc_status_next;
    reg  [31:0]  unc_mask_reg;
    reg  [31:0]  unc_sever_reg;
    reg  [4:0]   first_fault_position_reg;
    reg          log_held_reg;
    reg          log_held_next;
    reg          crc_gen_reg;
    reg          crc_ver_reg;
    reg  [127:0] logged_packet_header_reg;
    reg  [`RPAE_CMD_WIDTH-1:0] root_cmd_reg;
    reg  [`RPAE_FL_WIDTH-1:0]  flags_reg;
    reg  [`RPAE_FL_WIDTH-1:0]  flags_set;
    reg  [`RPAE_FL_WIDTH-1:0]  flags_clr;
    reg  [`RPAE_FL_WIDTH-1:0]  flags_next;
    reg  [15:0]  correctable_source_requester_reg;
    reg  [15:0]  uncorrectable_source_requester_reg;
    reg          msg_out_valid_reg;
    reg          msg_out_fatal_reg;
    reg          irq_reg;
    reg  [31:0]  rdata_reg;
    reg  [31:0]  rdata_next;
    reg          rvalid_reg;

    wire [31:0]  wmask;
    wire         is_cor;
    wire         is_nf;
    wire         is_fat;
    wire         is_unc;
    wire         wr_unc_status;
    wire         wr_flags;
    wire         capture;
    wire [31:0]  det_onehot;

    // ============================================================
    // Byte enables widened to bit lanes
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_lane
            assign wmask[g*8 +: 8] = {8{cfg_be[g]}};
        end
    endgenerate

    assign wr_unc_status = cfg_wr & (cfg_addr == `RPAE_OFS_UNC_STATUS);
    assign wr_flags      = cfg_wr & (cfg_addr == `RPAE_OFS_ROOT_FLAGS);
    assign det_onehot    = 32'h0000_0001 << det_bit;

    // ============================================================
    // Message classification
    rpae_msg_decode u_decode
    (
        .msg_valid (msg_valid),
        .msg_code  (msg_code),
        .is_cor    (is_cor),
        .is_nf     (is_nf),
        .is_fat    (is_fat)
    );

    assign is_unc = is_nf | is_fat;

    // ============================================================
    // Local uncorrectable status and header log
    // hold log while its bit stands
    assign capture = det_valid & ~log_held_reg;

    always @*
    begin
        unc_status_next = unc_status_reg;
        if (wr_unc_status)
            unc_status_next = unc_status_next & ~(cfg_wdata & wmask);
        if (det_valid)
            unc_status_next = unc_status_next | det_onehot;
        unc_status_next = unc_status_next & `RPAE_UNC_IMPL;

        // release log once its bit cleared
        log_held_next = log_held_reg;
        if (capture)
            log_held_next = 1'b1;
        else if (!unc_status_next[first_fault_position_reg])
            log_held_next = 1'b0;
    end

    always @(posedge clock)
    begin
        if (srst)
        begin
            unc_status_reg           <= 32'h0000_0000;
            log_held_reg             <= 1'b0;
            first_fault_position_reg <= 5'h00;
            logged_packet_header_reg <= 128'h0;
        end
        else
        begin
            unc_status_reg <= unc_status_next;
            log_held_reg   <= log_held_next;
            if (capture)
            begin
                first_fault_position_reg <= det_bit;
                logged_packet_header_reg <= det_header;
            end
        end
    end

    // ============================================================
    // Outgoing error message for local errors
    always @(posedge clock)
    begin
        if (srst)
        begin
            msg_out_valid_reg <= 1'b0;
            msg_out_fatal_reg <= 1'b0;
        end
        else
        begin
            msg_out_valid_reg <= det_valid & ~unc_mask_reg[det_bit];
            msg_out_fatal_reg <= det_valid & unc_sever_reg[det_bit];
        end
    end

    assign err_msg_valid = msg_out_valid_reg;
    assign err_msg_fatal = msg_out_fatal_reg & msg_out_valid_reg;

    // ============================================================
    // Writable control registers
    always @(posedge clock)
    begin
        if (srst)
        begin
            unc_mask_reg  <= `RPAE_UNC_MASK_RST;
            unc_sever_reg <= `RPAE_UNC_SEVER_RST;
            crc_gen_reg   <= 1'b0;
            crc_ver_reg   <= 1'b0;
            root_cmd_reg  <= {`RPAE_CMD_WIDTH{1'b0}};
        end
        else if (cfg_wr)
        begin
            case (cfg_addr)
                `RPAE_OFS_UNC_MASK:
                    unc_mask_reg <= ((unc_mask_reg & ~wmask) | (cfg_wdata & wmask))
                                    & `RPAE_UNC_IMPL;
                `RPAE_OFS_UNC_SEVER:
                    unc_sever_reg <= ((unc_sever_reg & ~wmask) | (cfg_wdata & wmask))
                                     & `RPAE_UNC_IMPL;
                `RPAE_OFS_CAP_CTRL:
                begin
                    if (cfg_be[0])
                        crc_gen_reg <= cfg_wdata[`RPAE_CC_GEN_ON];
                    if (cfg_be[1])
                        crc_ver_reg <= cfg_wdata[`RPAE_CC_VER_ON];
                end
                `RPAE_OFS_ROOT_CMD:
                    if (cfg_be[0])
                        root_cmd_reg <= cfg_wdata[`RPAE_CMD_WIDTH-1:0];
                default:
                    root_cmd_reg <= root_cmd_reg;
            endcase
        end
    end

    assign end_crc_generate_on = crc_gen_reg;
    assign end_crc_verify_on   = crc_ver_reg;

    // ============================================================
    // Root error flags from received messages
    always @*
    begin
        flags_set = {`RPAE_FL_WIDTH{1'b0}};
        flags_set[`RPAE_FL_COR_SEEN] = is_cor & ~flags_reg[`RPAE_FL_COR_SEEN];
        flags_set[`RPAE_FL_COR_REP]  = is_cor & flags_reg[`RPAE_FL_COR_SEEN];
        flags_set[`RPAE_FL_UNC_SEEN] = is_unc & ~flags_reg[`RPAE_FL_UNC_SEEN];
        flags_set[`RPAE_FL_UNC_REP]  = is_unc & flags_reg[`RPAE_FL_UNC_SEEN];
        flags_set[`RPAE_FL_FIRST_FAT] = is_fat & ~flags_reg[`RPAE_FL_UNC_SEEN];
        flags_set[`RPAE_FL_NF_ARR]   = is_nf;
        flags_set[`RPAE_FL_FAT_ARR]  = is_fat;

        flags_clr = {`RPAE_FL_WIDTH{1'b0}};
        if (wr_flags && cfg_be[0])
            flags_clr = cfg_wdata[`RPAE_FL_WIDTH-1:0];
        flags_next = (flags_reg & ~flags_clr) | flags_set;
    end

    always @(posedge clock)
    begin
        if (srst)
        begin
            flags_reg                          <= {`RPAE_FL_WIDTH{1'b0}};
            correctable_source_requester_reg   <= 16'h0000;
            uncorrectable_source_requester_reg <= 16'h0000;
        end
        else
        begin
            flags_reg <= flags_next;
            if (is_cor && !flags_reg[`RPAE_FL_COR_SEEN])
                correctable_source_requester_reg <= msg_req_id;
            if (is_unc && !flags_reg[`RPAE_FL_UNC_SEEN])
                uncorrectable_source_requester_reg <= msg_req_id;
        end
    end

    // ============================================================
    // Interrupt request, a level held while an enabled flag stands
    always @(posedge clock)
    begin
        if (srst)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= (root_cmd_reg[`RPAE_CMD_COR] & flags_next[`RPAE_FL_COR_SEEN])
                     | (root_cmd_reg[`RPAE_CMD_NF]  & flags_next[`RPAE_FL_NF_ARR])
                     | (root_cmd_reg[`RPAE_CMD_FAT] & flags_next[`RPAE_FL_FAT_ARR]);
        end
    end

    assign aer_irq_req           = irq_reg;
    assign aer_irq_vector_number = IRQ_VECTOR;

    // ============================================================
    // Read path; unmapped offsets read as zero
    always @*
    begin
        rdata_next = 32'h0000_0000;
        case (cfg_addr)
            `RPAE_OFS_UNC_STATUS: rdata_next = unc_status_reg;
            `RPAE_OFS_UNC_MASK:   rdata_next = unc_mask_reg;
            `RPAE_OFS_UNC_SEVER:  rdata_next = unc_sever_reg;
            `RPAE_OFS_CAP_CTRL:
            begin
                rdata_next[`RPAE_CC_PTR_HI:`RPAE_CC_PTR_LO] = first_fault_position_reg;
                rdata_next[`RPAE_CC_GEN_ABLE] = GEN_ABLE;
                rdata_next[`RPAE_CC_GEN_ON]   = crc_gen_reg;
                rdata_next[`RPAE_CC_VER_ABLE] = VER_ABLE;
                rdata_next[`RPAE_CC_VER_ON]   = crc_ver_reg;
            end
            `RPAE_OFS_HDR_DW0: rdata_next = logged_packet_header_reg[31:0];
            `RPAE_OFS_HDR_DW1: rdata_next = logged_packet_header_reg[63:32];
            `RPAE_OFS_HDR_DW2: rdata_next = logged_packet_header_reg[95:64];
            `RPAE_OFS_HDR_DW3: rdata_next = logged_packet_header_reg[127:96];
            `RPAE_OFS_ROOT_CMD: rdata_next[`RPAE_CMD_WIDTH-1:0] = root_cmd_reg;
            `RPAE_OFS_ROOT_FLAGS:
            begin
                rdata_next[`RPAE_FL_WIDTH-1:0]          = flags_reg;
                rdata_next[`RPAE_VEC_HI:`RPAE_VEC_LO]   = IRQ_VECTOR;
            end
            `RPAE_OFS_SRC_REQ:
                rdata_next = {uncorrectable_source_requester_reg,
                              correctable_source_requester_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always @(posedge clock)
    begin
        if (srst)
        begin
            rdata_reg  <= 32'h0000_0000;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rvalid_reg <= cfg_rd;
            if (cfg_rd)
            begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign cfg_rdata  = rdata_reg;
    assign cfg_rvalid = rvalid_reg;

endmodule // rpae_error_log
`default_nettype wire

// ### rpae_error_log_sva.sv
// Assertion checker for the root port error logging block
`timescale 1ns/1ps
`default_nettype none
`include "rpae_defines.vh"

module rpae_error_log_sva
#(
    parameter [4:0] IRQ_VECTOR = 5'h0
)
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        srst,
    // Configuration access
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        cfg_rvalid,
    // Error paths
    input wire logic        det_valid,
    input wire logic        err_msg_valid,
    input wire logic        msg_valid,
    input wire logic [7:0]  msg_code,
    // Watched outputs
    input wire logic        end_crc_generate_on,
    input wire logic        end_crc_verify_on,
    input wire logic        aer_irq_req,
    input wire logic [4:0]  aer_irq_vector_number
);
    // ==========================================================
    // Shadow of the interrupt enables
    logic [2:0] cmd_reg;
    wire        gen_wr = cfg_wr && (cfg_addr == `RPAE_OFS_CAP_CTRL) && cfg_be[0];
    wire        ver_wr = cfg_wr && (cfg_addr == `RPAE_OFS_CAP_CTRL) && cfg_be[1];
    always @(posedge clock)
    begin
        if (srst)
            cmd_reg <= 3'h0;
        else if (cfg_wr && (cfg_addr == `RPAE_OFS_ROOT_CMD) && cfg_be[0])
            cmd_reg <= cfg_wdata[2:0];
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    AST_READ_ANSWER: assert property (cfg_rd |=> cfg_rvalid)
        else $error("read strobe got no answer one cycle later");
    AST_RDATA_HOLDS: assert property (!cfg_rd |=> $stable(cfg_rdata))
        else $error("read data moved without a read");
    AST_RVALID_PULSE: assert property (!cfg_rd |=> !cfg_rvalid)
        else $error("read answer without a read strobe");
    AST_GEN_SET: assert property (gen_wr |=> end_crc_generate_on == $past(cfg_wdata[6]))
        else $error("crc generate enable does not follow its write");
    AST_VER_SET: assert property (ver_wr |=> end_crc_verify_on == $past(cfg_wdata[8]))
        else $error("crc check enable does not follow its write");
    AST_VECTOR_FIXED: assert property (aer_irq_vector_number == IRQ_VECTOR)
        else $error("interrupt vector number differs from its setting");
    AST_ERRMSG_CAUSE: assert property (err_msg_valid |-> $past(det_valid))
        else $error("error message sent without a detected error");
    AST_IRQ_NEEDS_ENABLE: assert property (aer_irq_req |-> $past(cmd_reg) != 3'h0)
        else $error("interrupt raised with all enables off");
    AST_COR_RAISES_IRQ: assert property ((msg_valid && msg_code == `RPAE_MSG_ERR_COR
        && cmd_reg[0] && !cfg_wr) |-> ##2 aer_irq_req)
        else $error("enabled correctable message raised no interrupt");
    AST_FAT_RAISES_IRQ: assert property ((msg_valid && msg_code == `RPAE_MSG_ERR_FAT
        && cmd_reg[2] && !cfg_wr) |-> ##2 aer_irq_req)
        else $error("enabled fatal message raised no interrupt");

    COV_READ: cover property (cfg_rvalid);
    COV_IRQ: cover property ($rose(aer_irq_req));
    COV_ERRMSG: cover property (err_msg_valid);
endmodule // rpae_error_log_sva

bind rpae_error_log rpae_error_log_sva #(.IRQ_VECTOR(IRQ_VECTOR)) u_sva
(
    .clock(clock), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .det_valid(det_valid), .err_msg_valid(err_msg_valid), .msg_valid(msg_valid),
    .msg_code(msg_code), .end_crc_generate_on(end_crc_generate_on),
    .end_crc_verify_on(end_crc_verify_on), .aer_irq_req(aer_irq_req),
    .aer_irq_vector_number(aer_irq_vector_number)
);
`default_nettype wire

// ### rpae_err_sender.sv
// Downstream device model that sends error messages
`timescale 1ns/1ps
`default_nettype none

module rpae_err_sender
(
    // Clock
    input  wire logic        clock,
    // Message lines
    output var  logic        msg_valid,
    output var  logic [7:0]  msg_code,
    output var  logic [15:0] msg_req_id
);
    initial
    begin
        msg_valid  = 1'b0;
        msg_code   = 8'h00;
        msg_req_id = 16'h0000;
    end

    task send(input logic [7:0] code, input logic [15:0] id);
        @(negedge clock);
        msg_valid  = 1'b1;
        msg_code   = code;
        msg_req_id = id;
        @(negedge clock);
        msg_valid  = 1'b0;
        // Idle lines show junk so a stale message cannot pass for a new one
        msg_code   = ~code;
        msg_req_id = ~id;
    endtask
endmodule // rpae_err_sender
`default_nettype wire

// ### rpae_error_log_test.sv
// Self-checking testbench for the root port error logging block
`timescale 1ns/1ps
`default_nettype none
`include "rpae_defines.vh"
`define CHK(got, want) \
    begin \
        samples_checked++; \
        if ((got) !== (want)) \
        begin \
            $display("unexpected at %0t: got %h want %h", $time, got, want); \
            fail_count++; \
        end \
    end

module rpae_error_log_test;
    localparam logic [127:0] H1 = 128'h4444_4444_3333_3333_2222_2222_1111_1111;
    localparam logic [127:0] H2 = 128'h8888_8888_7777_7777_6666_6666_5555_5555;
    logic         clock = 1'b0;
    logic         srst = 1'b1;
    logic         cfg_wr = 1'b0;
    logic         cfg_rd = 1'b0;
    logic [11:0]  cfg_addr = 12'h000;
    logic [3:0]   cfg_be = 4'h0;
    logic [31:0]  cfg_wdata = 32'h0000_0000;
    logic         det_valid = 1'b0;
    logic [4:0]   det_bit = 5'h00;
    logic [127:0] det_header = 128'h0;
    wire  [31:0]  cfg_rdata;
    wire          cfg_rvalid, err_msg_valid, err_msg_fatal, msg_valid, aer_irq_req;
    wire          end_crc_generate_on, end_crc_verify_on;
    wire  [7:0]   msg_code;
    wire  [15:0]  msg_req_id;
    wire  [4:0]   aer_irq_vector_number;
    int           fail_count = 0;
    int           samples_checked = 0;
    int           cycles = 0;

    always #2 clock = ~clock;

    rpae_error_log DUT
    (
        .clock(clock), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .det_valid(det_valid), .det_bit(det_bit), .det_header(det_header),
        .err_msg_valid(err_msg_valid), .err_msg_fatal(err_msg_fatal), .msg_valid(msg_valid),
        .msg_code(msg_code), .msg_req_id(msg_req_id), .end_crc_generate_on(end_crc_generate_on),
        .end_crc_verify_on(end_crc_verify_on), .aer_irq_req(aer_irq_req),
        .aer_irq_vector_number(aer_irq_vector_number)
    );

    rpae_err_sender u_peer
    (
        .clock(clock), .msg_valid(msg_valid), .msg_code(msg_code), .msg_req_id(msg_req_id)
    );

    task give_verdict;
        if (fail_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================
    // Bus cycles
    task wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge clock);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(negedge clock);
        cfg_wr = 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] want);
        @(negedge clock);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clock);
        cfg_rd = 1'b0;
        `CHK(cfg_rvalid, 1'b1)
        `CHK(cfg_rdata, want)
    endtask

    task det(input logic [4:0] b, input logic [127:0] h, input logic ev, input logic ef);
        @(negedge clock);
        det_valid = 1'b1;
        det_bit = b;
        det_header = h;
        @(negedge clock);
        det_valid = 1'b0;
        det_header = ~h;
        `CHK(err_msg_valid, ev)
        if (ev) `CHK(err_msg_fatal, ef)
    endtask

    task chk_log(input logic [127:0] h);
        int i;
        for (i = 0; i < 4; i++)
            rd(`RPAE_OFS_HDR_DW0 + 12'(4 * i), h[32 * i +: 32]);
    endtask

    // ==========================================================
    // Scenarios
    task t_reset;
        logic [11:0] a;
        wr(`RPAE_OFS_HDR_DW0, 4'hF, 32'hFFFF_FFFF);
        rd(`RPAE_OFS_CAP_CTRL, 32'h0000_0000);
        for (a = `RPAE_OFS_HDR_DW0; a <= `RPAE_OFS_SRC_REQ; a = a + 12'h004)
            rd(a, 32'h0000_0000);
        rd(12'h100, 32'h0000_0000);
        `CHK(aer_irq_vector_number, 5'h00)
    endtask

    task t_crc;
        `CHK(end_crc_generate_on, 1'b0)
        `CHK(end_crc_verify_on, 1'b0)
        wr(`RPAE_OFS_CAP_CTRL, 4'h3, 32'h0000_01FF);
        `CHK(end_crc_generate_on, 1'b1)
        `CHK(end_crc_verify_on, 1'b1)
        rd(`RPAE_OFS_CAP_CTRL, 32'h0000_0140);
        wr(`RPAE_OFS_CAP_CTRL, 4'h1, 32'h0000_0000);
        `CHK(end_crc_generate_on, 1'b0)
        `CHK(end_crc_verify_on, 1'b1)
    endtask

    task t_cor;
        u_peer.send(`RPAE_MSG_ERR_COR, 16'h1234);
        @(negedge clock);
        `CHK(aer_irq_req, 1'b0)
        rd(`RPAE_OFS_ROOT_FLAGS, 32'h0000_0001);
        wr(`RPAE_OFS_ROOT_CMD, 4'h1, 32'h0000_0001);
        @(negedge clock);
        `CHK(aer_irq_req, 1'b1)
        u_peer.send(`RPAE_MSG_ERR_COR, 16'h5678);
        rd(`RPAE_OFS_ROOT_FLAGS, 32'h0000_0003);
        rd(`RPAE_OFS_SRC_REQ, 32'h0000_1234);
        wr(`RPAE_OFS_ROOT_FLAGS, 4'hF, 32'h0000_0000);
        rd(`RPAE_OFS_ROOT_FLAGS, 32'h0000_0003);
        wr(`RPAE_OFS_ROOT_FLAGS, 4'hF, 32'h0000_0003);
        rd(`RPAE_OFS_ROOT_FLAGS, 32'h0000_0000);
        `CHK(aer_irq_req, 1'b0)
    endtask

    task t_unc;
        wr(`RPAE_OFS_ROOT_CMD, 4'h1, 32'h0000_0002);
        u_peer.send(`RPAE_MSG_ERR_NF, 16'hAAAA);
        @(negedge clock);
        `CHK(aer_irq_req, 1'b1)
        u_peer.send(`RPAE_MSG_ERR_FAT, 16'hBBBB);
        rd(`RPAE_OFS_ROOT_FLAGS, 32'h0000_006C);
        rd(`RPAE_OFS_SRC_REQ, 32'hAAAA_1234);
        wr(`RPAE_OFS_ROOT_FLAGS, 4'h1, 32'h0000_007F);
        wr(`RPAE_OFS_ROOT_CMD, 4'h1, 32'h0000_0004);
        u_peer.send(`RPAE_MSG_ERR_FAT, 16'hCCCC);
        @(negedge clock);
        `CHK(aer_irq_req, 1'b1)
        u_peer.send(8'h32, 16'hDDDD);
        rd(`RPAE_OFS_ROOT_FLAGS, 32'h0000_0054);
        rd(`RPAE_OFS_SRC_REQ, 32'hCCCC_1234);
        wr(`RPAE_OFS_ROOT_FLAGS, 4'h1, 32'h0000_007F);
        wr(`RPAE_OFS_ROOT_CMD, 4'h1, 32'h0000_0000);
    endtask

    task t_det;
        det(5'h12, H1, 1'b1, 1'b1);
        rd(`RPAE_OFS_UNC_STATUS, 32'h0004_0000);
        rd(`RPAE_OFS_CAP_CTRL, 32'h0000_0112);
        chk_log(H1);
        det(5'h0C, H2, 1'b1, 1'b0);
        rd(`RPAE_OFS_CAP_CTRL, 32'h0000_0112);
        chk_log(H1);
        wr(`RPAE_OFS_UNC_STATUS, 4'hF, 32'h0004_0000);
        det(5'h0E, H2, 1'b1, 1'b0);
        rd(`RPAE_OFS_CAP_CTRL, 32'h0000_010E);
        chk_log(H2);
        wr(`RPAE_OFS_UNC_SEVER, 4'hF, 32'h0006_3030);
        det(5'h0C, H1, 1'b1, 1'b1);
        wr(`RPAE_OFS_UNC_MASK, 4'hF, 32'h0000_2000);
        det(5'h0D, H1, 1'b0, 1'b0);
    endtask

    // ==========================================================
    // Watchdog and main sequence
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (8) @(posedge clock);
        @(negedge clock);
        srst = 1'b0;
        t_reset();
        t_crc();
        t_cor();
        t_unc();
        t_det();
        give_verdict();
    end
endmodule // rpae_error_log_test
`default_nettype wire
